// >>> iac_accept_ctrl.v
// Interrupt acceptance controller with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "iac_regs.vh"
module iac_accept_ctrl (
	input wire ref_clk_i,
	input wire reset_n_i,
	// AXI4-Lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// External interrupt edges and internal source requests
	input wire [7:0] ext_irq_event_i,
	input wire [7:0] int_irq_req_i,
	input wire nmi_i,
	input wire standby_i,
	// CPU core status
	input wire instr_end_i,
	input wire ctrl_instr_i,
	input wire block_move_byte_i,
	input wire block_move_word_i,
	input wire xfer_boundary_i,
	input wire accept_i,
	// Request toward the CPU
	output wire cpu_irq_req_o,
	output reg [3:0] cpu_irq_src_o,
	output reg cpu_irq_nmi_o,
	output reg [7:0] ext_irq_status_reg_o
);
	// Source numbering: 0..7 external, 8..15 internal; lower wins
	// Register map, one byte lane used per word:
	//   status  - pending flags, a zero written clears that flag
	//   enable  - per-flag enable, applied when the instruction ends
	//   hwclr   - flags that clear themselves when their request is taken
	//   ctrl    - bit 0 is the CPU mask, set again on each maskable take
	//   accept  - source number of the last request the core took
	// Limitation: only lane 0 of a write is honoured; other lanes are
	// ignored, so a word write behaves like the byte write software uses.
	reg [7:0] enable_r;
	reg [7:0] enable_nxt;
	reg [7:0] hwclr_r;
	reg mask_r;
	reg [7:0] pend_clr_r;
	reg req_r;
	reg [3:0] last_src_r;
	reg aw_held_r;
	reg w_held_r;
	reg [7:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	wire [7:0] flags;
	wire [7:0] sw_clr;
	wire [7:0] hw_clr;
	wire wr_fire;
	wire [15:0] req_vec;
	wire [15:0] live_vec;
	wire [3:0] sel_src;
	wire sel_valid;
	wire maskable_ok;
	wire nmi_ok;
	wire take;
	wire [4:0] pick;
	wire hold;
	wire ctrl_block;

	// Priority encoder, used only by source selection
	function [4:0] pick_first;
		input [15:0] v;
		integer i;
		begin
			pick_first = 5'h00;
			for (i = `IAC_NUM_SRC - 1; i >= 0; i = i - 1) begin
				if (v[i])
					pick_first = {1'b1, i[3:0]};
			end
		end
	endfunction

	// Address decode used by both write and read paths
	function [2:0] decode;
		input [7:0] a;
		begin
			case (a)
				`IAC_ADDR_STATUS: decode = 3'h1;
				`IAC_ADDR_ENABLE: decode = 3'h2;
				`IAC_ADDR_HWCLR: decode = 3'h3;
				`IAC_ADDR_CTRL: decode = 3'h4;
				`IAC_ADDR_ACCEPT: decode = 3'h5;
				default: decode = 3'h0;
			endcase
		end
	endfunction

	// Write channels: address and data taken in either order
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready = !w_held_r && !s_axi_bvalid;
	assign wr_fire = aw_held_r && w_held_r;

	always @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `IAC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (decode(aw_addr_r) == 3'h0) ? `IAC_RESP_SLVERR : `IAC_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Software clear: any zero written into a status byte clears that flag,
	// no matter whether it was read as one first (the flaw software works around)
	assign sw_clr = (wr_fire && decode(aw_addr_r) == 3'h1 && w_strb_r[0]) ?
		~w_data_r[7:0] : 8'h00; // RQ11 RQ12 RQ14

	// Enable writes are held back until the current instruction ends
	always @* begin
		enable_nxt = enable_r;
		if (wr_fire && decode(aw_addr_r) == 3'h2 && w_strb_r[0])
			enable_nxt = w_data_r[7:0];
	end

	// Pending enable/flag updates are staged and released at instruction end
	reg [7:0] en_stage_r;
	reg en_stage_v_r;
	always @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			enable_r <= `IAC_ENABLE_RST;
			en_stage_r <= `IAC_ENABLE_RST;
			en_stage_v_r <= 1'b0;
			pend_clr_r <= 8'h00;
			hwclr_r <= `IAC_HWCLR_RST;
			mask_r <= 1'b1;
		end else begin
			if (wr_fire && decode(aw_addr_r) == 3'h2 && w_strb_r[0]) begin
				en_stage_r <= enable_nxt;
				en_stage_v_r <= 1'b1;
			end
			if (instr_end_i && en_stage_v_r) begin
				enable_r <= en_stage_r; // RQ1
				en_stage_v_r <= 1'b0;
			end
			// Flag clears also wait for the instruction to complete.
			// The store empties once applied, but a flag that sets again before
			// the instruction ends, in a later cycle than the write, is still cleared.
			if (instr_end_i)
				pend_clr_r <= 8'h00; // RQ3
			else
				pend_clr_r <= pend_clr_r | sw_clr;
			if (wr_fire && decode(aw_addr_r) == 3'h3 && w_strb_r[0])
				hwclr_r <= w_data_r[7:0];
			if (wr_fire && decode(aw_addr_r) == 3'h4 && w_strb_r[0])
				mask_r <= w_data_r[`IAC_CTRL_MASK_BIT];
			else if (take && !cpu_irq_nmi_o)
				mask_r <= 1'b1; // Acceptance masks further maskable requests
		end
	end

	// Flag store: staged clears land at instruction end; hw clear on entry
	assign hw_clr = (take && !cpu_irq_nmi_o && cpu_irq_src_o < 4'h8) ?
		(hwclr_r & (8'h01 << cpu_irq_src_o[2:0])) : 8'h00; // RQ13
	iac_pending_flags u_flags (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.set_i(ext_irq_event_i),
		.sw_clr_i(instr_end_i ? (pend_clr_r | sw_clr) : 8'h00),
		.hw_clr_i(hw_clr),
		.flags_o(flags)
	);

	// Request vector: disabled sources are ignored
	assign req_vec = {int_irq_req_i, flags & enable_r}; // RQ17
	assign live_vec = req_vec;
	// One priority decision, shared by the valid bit and the source number
	assign pick = pick_first(live_vec);
	assign sel_valid = pick[4]; // RQ2 RQ5
	assign sel_src = pick[3:0];

	// A control instruction ending now hides this boundary from acceptance,
	// so the core always runs one more instruction before taking anything.
	// Kept combinational: a registered flag would block the wrong boundary.
	assign ctrl_block = instr_end_i && ctrl_instr_i; // RQ6

	// Gating: byte move holds off everything, word move only maskables
	assign maskable_ok = sel_valid && !mask_r && !ctrl_block && !block_move_byte_i &&
		!block_move_word_i && instr_end_i; // RQ7 RQ8 RQ18
	assign nmi_ok = nmi_i && !standby_i && !block_move_byte_i && !ctrl_block &&
		(block_move_word_i ? xfer_boundary_i : instr_end_i); // RQ9 RQ17

	// A raised request stands until the core takes it: the core takes only
	// at an instruction end or, for NMI, at a word-move transfer boundary,
	// which may be several cycles after the decision
	assign hold = req_r && !take;

	// Request is presented only after the priority decision is registered.
	// While waiting, a better source still replaces the one on show.
	always @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			cpu_irq_src_o <= 4'h0;
			cpu_irq_nmi_o <= 1'b0;
			last_src_r <= 4'h0;
		end else begin
			if (hold)
				cpu_irq_nmi_o <= cpu_irq_nmi_o || nmi_ok;
			else
				cpu_irq_nmi_o <= nmi_ok;
			if (!hold || sel_valid)
				cpu_irq_src_o <= sel_src; // RQ5
			if (take)
				last_src_r <= cpu_irq_src_o;
		end
	end

	// Request level toward the core, dropped the cycle after a take
	always @(posedge ref_clk_i) begin
		if (!reset_n_i)
			req_r <= 1'b0;
		else
			req_r <= hold || ((nmi_ok || maskable_ok) && !take);
	end
	assign cpu_irq_req_o = req_r;
	assign take = req_r && accept_i;

	// Status mirror for the CPU side
	always @(posedge ref_clk_i) begin
		if (!reset_n_i)
			ext_irq_status_reg_o <= `IAC_STATUS_RST;
		else
			ext_irq_status_reg_o <= flags; // RQ20
	end

	// Read channel: one read at a time, registered data
	assign s_axi_arready = !s_axi_rvalid;
	always @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `IAC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `IAC_RESP_OKAY;
			case (decode(s_axi_araddr))
				3'h1: s_axi_rdata <= {24'h000000, flags};
				3'h2: s_axi_rdata <= {24'h000000, enable_r};
				3'h3: s_axi_rdata <= {24'h000000, hwclr_r};
				3'h4: s_axi_rdata <= {31'h00000000, mask_r};
				3'h5: s_axi_rdata <= {28'h0000000, last_src_r};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `IAC_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule // iac_accept_ctrl
`default_nettype wire

// >>> iac_regs.vh
// Constants for the interrupt acceptance and flag handling block
// Operation
// (RQ1) Cleared enable stays live until instruction ends
// (RQ2) Higher priority request wins at instruction end
// (RQ3) Flag clear takes effect after instruction ends
// (RQ4) Software masks interrupts while clearing enables
// (RQ5) Resolve priority before requesting the CPU
// (RQ6) After control instructions, run next instruction first
// (RQ7) Byte block move blocks all interrupts, NMI too
// (RQ8) Word block move blocks maskable interrupts only
// (RQ9) NMI in word move stops at transfer boundary
// (RQ10) Software retests remaining count after word move
// (RQ11) Pending flag intended clear: write zero after read
// (RQ12) Writing zero clears pending flag unconditionally
// (RQ13) Hardware-cleared flag clears on exception entry
// (RQ14) Zero write after auto clear avoids loss
// (RQ15) Software clears flag by byte read-modify-write
// (RQ16) Handler dummy-writes zero to own flag
// (RQ17) NMI always accepted (code holds NMI off in standby, byte moves and at control-instruction ends); disabled sources ignored
// (RQ18) Mask bit set admits only NMI
// (RQ19) Set wins over coincident software clear
// (RQ20) Status bit n reflects external interrupt n
`ifndef IAC_REGS_VH
`define IAC_REGS_VH
`define IAC_NUM_EXT 8
`define IAC_NUM_SRC 16
`define IAC_SRC_W 4
`define IAC_ADDR_STATUS 8'h00
`define IAC_ADDR_ENABLE 8'h04
`define IAC_ADDR_HWCLR 8'h08
`define IAC_ADDR_CTRL 8'h0C
`define IAC_ADDR_ACCEPT 8'h10
`define IAC_CTRL_MASK_BIT 0
`define IAC_STATUS_RST 8'h00
`define IAC_ENABLE_RST 8'h00
`define IAC_HWCLR_RST 8'h00
`define IAC_RESP_OKAY 2'b00
`define IAC_RESP_SLVERR 2'b10
`endif

// >>> iac_pending_flags.v
// Pending flag store for the external interrupts
`timescale 1ns/1ps
`default_nettype none
`include "iac_regs.vh"
module iac_pending_flags (
	input wire ref_clk_i,
	input wire reset_n_i,
	input wire [7:0] set_i,
	input wire [7:0] sw_clr_i,
	input wire [7:0] hw_clr_i,
	output reg [7:0] flags_o
);
	genvar g;
	// Each flag: set beats any clear in the same cycle
	generate
		for (g = 0; g < `IAC_NUM_EXT; g = g + 1) begin : g_flag
			always @(posedge ref_clk_i) begin
				if (!reset_n_i)
					flags_o[g] <= 1'b0;
				else if (set_i[g])
					flags_o[g] <= 1'b1; // RQ19 RQ20
				else if (sw_clr_i[g] || hw_clr_i[g])
					flags_o[g] <= 1'b0; // RQ12 RQ13
			end
		end
	endgenerate
endmodule // iac_pending_flags
`default_nettype wire

// >>> iac_accept_ctrl_sva.sv
// Port checks for the interrupt acceptance block
`timescale 1ns/1ps
`default_nettype none
module iac_accept_ctrl_sva (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] ext_irq_event_i,
	input wire logic nmi_i,
	input wire logic block_move_byte_i,
	input wire logic block_move_word_i,
	input wire logic accept_i,
	input wire logic cpu_irq_req_o,
	input wire logic cpu_irq_nmi_o,
	input wire logic [7:0] ext_irq_status_reg_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Steps of a read and of a flag set
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence ev0_rise;
		$rose(ext_irq_event_i[0]);
	endsequence
	rd_resp_a: assert property (rd_take |=> s_axi_rvalid)
		else $error("no read answer");
	b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid stuck");
	r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid stuck");
	byte_move_a: assert property (block_move_byte_i[*3] |-> !$rose(cpu_irq_req_o))
		else $error("request in byte move");
	word_move_a: assert property (block_move_word_i[*3] ##0 $rose(cpu_irq_req_o) |-> cpu_irq_nmi_o)
		else $error("maskable in word move");
	accept_drop_a: assert property (accept_i && cpu_irq_req_o |=> !cpu_irq_req_o)
		else $error("request after take");
	nmi_cause_a: assert property ($rose(cpu_irq_req_o) && cpu_irq_nmi_o |-> $past(nmi_i))
		else $error("nmi without cause");
	flag_set_a: assert property (ev0_rise |-> ##[1:2] ext_irq_status_reg_o[0])
		else $error("flag 0 not set");
endmodule // iac_accept_ctrl_sva
`default_nettype wire

// >>> iac_cpu_model.sv
// Behavioural CPU core that ends instructions and takes requests
`timescale 1ns/1ps
`default_nettype none
module iac_cpu_model (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic [1:0] len_i,
	input wire logic ctrl_i,
	input wire logic byte_i,
	input wire logic word_i,
	input wire logic req_i,
	input wire logic nmi_i,
	output logic end_o,
	output logic xfer_o,
	output logic accept_o
);
	logic [1:0] cnt_r;
	// Slow instructions last up to four cycles
	always @(posedge ref_clk_i) begin
		if (!reset_n_i)
			cnt_r <= 2'h0;
		else
			cnt_r <= (cnt_r == 2'h0) ? len_i : cnt_r - 2'h1;
	end
	// A block move never ends while it transfers
	assign end_o = reset_n_i && cnt_r == 2'h0 && !byte_i && !word_i;
	assign xfer_o = reset_n_i && cnt_r == 2'h0 && word_i;
	// No take after a control instruction; only NMI cuts a word move
	assign accept_o = req_i && ((end_o && !ctrl_i) || (xfer_o && nmi_i));
endmodule // iac_cpu_model
`default_nettype wire

// >>> test_iac_accept_ctrl.sv
// Self-checking bench for the interrupt acceptance block
`timescale 1ns/1ps
`default_nettype none
`include "iac_regs.vh"
module test_iac_accept_ctrl;
	logic ref_clk_i = 1'h0, reset_n_i = 1'h0, nmi_i = 1'h0, standby_i = 1'h0, seen;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ctrl_instr_i = 1'h0;
	logic block_move_byte_i = 1'h0, block_move_word_i = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ext_irq_event_i = 8'h00;
	logic [7:0] int_irq_req_i = 8'h00, lfsr = 8'h5D, flags = 8'h00, k;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h1, last_src = 4'hF;
	logic [1:0] len = 2'h0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire cpu_irq_req_o, cpu_irq_nmi_o, instr_end_i, xfer_boundary_i, accept_i;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [3:0] cpu_irq_src_o;
	wire [7:0] ext_irq_status_reg_o;
	int mismatches = 0, tests_run = 0;
	iac_accept_ctrl i_iac_accept_ctrl (.*);
	iac_cpu_model i_cpu (.ref_clk_i, .reset_n_i, .len_i(len), .ctrl_i(ctrl_instr_i),
		.byte_i(block_move_byte_i), .word_i(block_move_word_i), .req_i(cpu_irq_req_o),
		.nmi_i, .end_o(instr_end_i), .xfer_o(xfer_boundary_i), .accept_o(accept_i));
	initial forever #5 ref_clk_i = ~ref_clk_i;
	// Source seen when the core takes a request
	always @(posedge ref_clk_i) if (accept_i && cpu_irq_req_o) last_src <= cpu_irq_src_o;
	function automatic logic [7:0] nxt(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Write: both halves offered at once, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge ref_clk_i);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge ref_clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge ref_clk_i);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		chk("rdata", e, s_axi_rdata);
		chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
	endtask
	task automatic pulse(input logic [7:0] ev);
		@(posedge ref_clk_i);
		ext_irq_event_i <= ev;
		@(posedge ref_clk_i);
		ext_irq_event_i <= 8'h00;
		repeat (3) @(posedge ref_clk_i);
	endtask
	// Hang guard, far beyond the few hundred cycles used
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		mismatches++;
		end_sim;
	end
	initial begin
		repeat (4) @(posedge ref_clk_i);
		reset_n_i <= 1'h1;
		rd(`IAC_ADDR_STATUS, 32'h0, `IAC_RESP_OKAY);
		rd(`IAC_ADDR_ENABLE, 32'h0, `IAC_RESP_OKAY);
		rd(`IAC_ADDR_HWCLR, 32'h0, `IAC_RESP_OKAY);
		rd(`IAC_ADDR_CTRL, 32'h1, `IAC_RESP_OKAY);
		rd(8'h40, 32'h0, `IAC_RESP_SLVERR);
		// NMI held off by a byte move, cut in by a word move
		for (int m = 0; m < 2; m++) begin
			seen = 1'h0;
			block_move_byte_i <= (m == 0);
			block_move_word_i <= (m == 1);
			nmi_i <= 1'h1;
			repeat (10) begin
				@(posedge ref_clk_i);
				seen |= cpu_irq_req_o;
			end
			chk("nmi_in_move", m, seen);
			block_move_byte_i <= 1'h0;
			block_move_word_i <= 1'h0;
			for (int n = 0; n < 50 && cpu_irq_req_o !== 1'h1; n++) @(posedge ref_clk_i);
			chk("nmi_flag", 1, cpu_irq_nmi_o);
			nmi_i <= 1'h0;
			repeat (8) @(posedge ref_clk_i);
		end
		// Random flag sets and byte write-back clears, slow instructions too
		for (int i = 0; i < 6; i++) begin
			lfsr = nxt(lfsr);
			len <= lfsr[1:0];
			ctrl_instr_i <= lfsr[2];
			pulse(lfsr);
			flags |= lfsr;
			rd(`IAC_ADDR_STATUS, {24'h0, flags}, `IAC_RESP_OKAY);
			lfsr = nxt(lfsr);
			k = 8'h01 << lfsr[2:0];
			wr(`IAC_ADDR_STATUS, {24'h0, ~k});
			flags &= ~k;
			repeat (8) @(posedge ref_clk_i);
			chk("status", flags, ext_irq_status_reg_o);
		end
		// Two maskable sources at once, lower index wins, hardware clear
		ctrl_instr_i <= 1'h0;
		wr(`IAC_ADDR_STATUS, 32'h0);
		wr(`IAC_ADDR_HWCLR, 32'h4);
		wr(`IAC_ADDR_ENABLE, 32'hFF);
		wr(`IAC_ADDR_CTRL, 32'h0);
		pulse(8'h24);
		repeat (10) @(posedge ref_clk_i);
		chk("src", 2, last_src);
		rd(`IAC_ADDR_ACCEPT, 32'h2, `IAC_RESP_OKAY);
		rd(`IAC_ADDR_STATUS, 32'h20, `IAC_RESP_OKAY);
		rd(`IAC_ADDR_CTRL, 32'h1, `IAC_RESP_OKAY);
		end_sim;
	end
endmodule // test_iac_accept_ctrl
bind iac_accept_ctrl iac_accept_ctrl_sva i_iac_accept_ctrl_sva (.*);
`default_nettype wire
